// file: design/tee_pkg.sv
package tee_pkg;
	// register offsets
	localparam logic [4:0] OFF_PSR = 5'h00;
	localparam logic [4:0] OFF_TBR = 5'h04;
	localparam logic [4:0] OFF_FSR = 5'h08;
	localparam logic [4:0] OFF_FTC = 5'h0C;
	localparam logic [4:0] OFF_INJ = 5'h10;
	localparam logic [4:0] OFF_PC  = 5'h14;
	localparam logic [4:0] OFF_NPC = 5'h18;
	// proc_state_reg fields
	localparam int PSR_CWP_LO = 0;
	localparam int PSR_ET     = 5;
	localparam int PSR_PS     = 6;
	localparam int PSR_S      = 7;
	localparam int PSR_PIL_LO = 8;
	// fp_state_reg fields
	localparam int FSR_FP_ACCRUED_FLAGS_LO = 5;
	localparam int FSR_FCC_LO  = 10;
	localparam int FSR_TEM_LO  = 23;
	// trap_base_reg fields
	localparam int TBR_TT_LO  = 4;
	localparam int TBR_TBA_LO = 12;
	// regfile_ft_ctrl fields
	localparam int FTC_CNT_LO = 0;
	localparam int FTC_TCB_LO = 16;
	localparam int FTC_CNTEN  = 28;
	localparam int FTC_KEY_LO = 29;
	localparam logic [2:0] FTC_KEY = 3'h5;
	// values after reset
	localparam logic       RST_ET  = 1'b0;
	localparam logic       RST_S   = 1'b1;
	localparam logic [3:0] RST_PIL = 4'h0;
	// trap vectors
	localparam logic [31:0] RESET_PC = 32'h0000_0000;
	localparam logic [31:0] PC_STEP  = 32'h0000_0004;
	localparam logic [7:0]  TT_IRQ   = 8'h10;
	localparam logic [7:0]  TT_SW    = 8'h80;
	// synchronous exceptions, index 0 is highest priority
	localparam int NEXC    = 16;
	localparam int EXC_RF  = 9;
	localparam int EXC_FP  = 11;
	localparam int EXC_SW  = 15;
	localparam logic [7:0] EXC_TT [NEXC] = '{8'h2B, 8'h01, 8'h03, 8'h02, 8'h04, 8'h24, 8'h0B, 8'h05,
		8'h06, 8'h20, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h2A, 8'h80};
	// register file layout
	localparam int NGLOB  = 8;
	localparam int WIN_SZ = 16;
	localparam int LOC1   = 1;
	localparam int LOC2   = 2;
endpackage : tee_pkg

// file: design/tee_trap_unit.sv
`timescale 1ns/1ps
module tee_trap_unit
	import tee_pkg::*;
#(
	parameter int NWIN = 8
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// register port
	input  wire logic [4:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// pipeline trap requests
	input  wire logic        resetReq,
	input  wire logic        excValid,
	input  wire logic [15:0] excPend,
	input  wire logic [6:0]  swTrapNum,
	input  wire logic        instrDone,
	input  wire logic [3:0]  irqLevel,
	input  wire logic [31:0] curPc,
	input  wire logic [31:0] curNpc,
	// trap results
	output logic             trapTaken,
	output logic      [7:0]  trapType,
	output logic      [31:0] trapPc,
	output logic      [31:0] trapNpc,
	output logic             halted,
	output logic             trapEnable,
	output logic             supervisor,
	output logic      [$clog2(NWIN)-1:0] current_window_ptr,
	// floating-point unit
	input  wire logic        fpValid,
	input  wire logic [4:0]  fpExc,
	input  wire logic [1:0]  fpCcNew,
	output logic             fpCommit,
	output logic      [1:0]  fpCondCodes,
	// register file access
	input  wire logic        rfWrEn,
	input  wire logic [7:0]  rfWrIdx,
	input  wire logic [31:0] rfWrData,
	input  wire logic        rfRdEn,
	input  wire logic [7:0]  rfRdIdx,
	output logic      [31:0] rfRdData,
	output logic             rfRdValid
);
	localparam int CWPW = $clog2(NWIN);
	localparam int NREG = NGLOB + NWIN * WIN_SZ;

	////////////////////////////////////////////////////////////////////////////////
	// checksum and priority-select functions
	function automatic logic [6:0] eccCheck(input logic [31:0] d);
		logic [6:0] c;
		int         k;
		c = '0;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int i = 0; i < 6; i++) begin
					if (p[i]) c[i] ^= d[k];
				end
				k++;
			end
		end
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction : eccCheck

	function automatic logic [31:0] eccFix(input logic [31:0] d, input logic [5:0] syn);
		logic [31:0] r;
		int          k;
		r = d;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (p[5:0] == syn) r[k] = ~r[k];
				k++;
			end
		end
		return r;
	endfunction : eccFix

	function automatic logic [3:0] firstSet(input logic [NEXC-1:0] v);
		logic [3:0] r;
		r = '0;
		for (int i = NEXC - 1; i >= 0; i--) begin
			if (v[i]) r = 4'(i);
		end
		return r;
	endfunction : firstSet

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic        prevSup;
	logic [3:0]  cpu_irq_level;
	logic [19:0] trap_table_base;
	logic [4:0]  fpTrapMask;
	logic [4:0]  fpAccrued;
	logic [2:0]  injKey;
	logic        cntEn;
	logic [6:0]  testChk;
	logic [7:0]  singleCnt;
	logic [31:0] injData;
	logic        rfErrFlag;
	logic        fpTrapFlag;
	logic [31:0] rfData [NREG];
	logic [6:0]  rfChk  [NREG];

	////////////////////////////////////////////////////////////////////////////////
	// register decode
	wire logic wrPsr = regWr && regAddr == OFF_PSR;
	wire logic wrTbr = regWr && regAddr == OFF_TBR;
	wire logic wrFsr = regWr && regAddr == OFF_FSR;
	wire logic wrFtc = regWr && regAddr == OFF_FTC;
	wire logic wrInj = regWr && regAddr == OFF_INJ;

	logic [31:0] psrVal;
	logic [31:0] fsrVal;
	logic [31:0] ftcVal;
	wire  logic [31:0] tbrVal = {trap_table_base, trapType, 4'h0};
	always_comb begin
		psrVal = '0;
		psrVal[PSR_CWP_LO +: CWPW] = current_window_ptr;
		psrVal[PSR_ET] = trapEnable;
		psrVal[PSR_PS] = prevSup;
		psrVal[PSR_S] = supervisor;
		psrVal[PSR_PIL_LO +: 4] = cpu_irq_level;
		fsrVal = '0;
		fsrVal[FSR_FP_ACCRUED_FLAGS_LO +: 5] = fpAccrued;
		fsrVal[FSR_FCC_LO +: 2] = fpCondCodes;
		fsrVal[FSR_TEM_LO +: 5] = fpTrapMask;
		ftcVal = '0;
		ftcVal[FTC_CNT_LO +: 8] = singleCnt;
		ftcVal[FTC_TCB_LO +: 7] = testChk;
		ftcVal[FTC_CNTEN] = cntEn;
		ftcVal[FTC_KEY_LO +: 3] = injKey;
	end
	wire logic [31:0] rdMux = regAddr == OFF_PSR ? psrVal :
		regAddr == OFF_TBR ? tbrVal :
		regAddr == OFF_FSR ? fsrVal :
		regAddr == OFF_FTC ? ftcVal :
		regAddr == OFF_INJ ? injData :
		regAddr == OFF_PC ? trapPc :
		regAddr == OFF_NPC ? trapNpc : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// trap selection
	wire logic [NEXC-1:0] excAll = ({NEXC{excValid}} & excPend) | (NEXC'(rfErrFlag) << EXC_RF)
		| (NEXC'(fpTrapFlag) << EXC_FP);
	wire logic [3:0] excIdx = firstSet(excAll);
	wire logic syncHit = (|excAll) && !halted && !resetReq;
	wire logic irqHit = instrDone && trapEnable && irqLevel > cpu_irq_level && !syncHit && !halted
		&& !resetReq;
	wire logic takeTrap = trapEnable && (syncHit || irqHit);
	wire logic goHalt = !trapEnable && syncHit;
	wire logic [7:0] selTt = !syncHit ? (TT_IRQ | {4'h0, irqLevel}) :
		excIdx == 4'(EXC_SW) ? (TT_SW | {1'b0, swTrapNum}) : EXC_TT[excIdx];
	wire logic [CWPW-1:0] newCwp = current_window_ptr - CWPW'(1);
	wire logic [7:0] locBase = 8'(NGLOB) + 8'(newCwp) * 8'(WIN_SZ);
	wire logic [7:0] l1Idx = locBase + 8'(LOC1);
	wire logic [7:0] l2Idx = locBase + 8'(LOC2);

	////////////////////////////////////////////////////////////////////////////////
	// register file checking, always on
	wire logic [31:0] rdWord = rfData[rfRdIdx];
	wire logic [6:0]  rdChk = rfChk[rfRdIdx];
	wire logic [6:0]  calcChk = eccCheck(rdWord);
	wire logic [5:0]  syn = calcChk[5:0] ^ rdChk[5:0];
	wire logic singleErr = ^{rdWord, rdChk};
	wire logic dblErr = !singleErr && syn != 6'h00;
	wire logic [31:0] fixWord = eccFix(rdWord, syn);
	wire logic injOn = injKey == FTC_KEY;
	wire logic [31:0] wrWord = injOn ? rfWrData ^ injData : rfWrData;
	wire logic [6:0]  wrChk = injOn ? eccCheck(rfWrData) ^ testChk : eccCheck(rfWrData);

	////////////////////////////////////////////////////////////////////////////////
	// floating-point gating
	wire logic fpTrapNow = fpValid && (|(fpExc & fpTrapMask));
	wire logic fpAccept = fpValid && !fpTrapNow;

	////////////////////////////////////////////////////////////////////////////////
	// storage
	always_ff @(posedge clk) begin
		if (rfRdEn && (singleErr || dblErr == 1'b0 && syn != 6'h00)) begin
			rfData[rfRdIdx] <= fixWord;
			rfChk[rfRdIdx] <= eccCheck(fixWord);
		end
		if (rfWrEn) begin
			rfData[rfWrIdx] <= wrWord;
			rfChk[rfWrIdx] <= wrChk;
		end
		if (takeTrap) begin
			rfData[l1Idx] <= curPc;
			rfChk[l1Idx] <= eccCheck(curPc);
			rfData[l2Idx] <= curNpc;
			rfChk[l2Idx] <= eccCheck(curNpc);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// processor state
	always_ff @(posedge clk) begin
		if (srst) begin
			trapEnable <= RST_ET;
			supervisor <= RST_S;
			prevSup <= RST_S;
			current_window_ptr <= '0;
			cpu_irq_level <= RST_PIL;
			halted <= 1'b0;
		end else if (resetReq) begin
			trapEnable <= 1'b0;
			supervisor <= 1'b1;
			halted <= 1'b0;
		end else if (takeTrap) begin
			trapEnable <= 1'b0;
			prevSup <= supervisor;
			supervisor <= 1'b1;
			current_window_ptr <= newCwp;
		end else if (goHalt) begin
			halted <= 1'b1;
		end else if (wrPsr) begin
			trapEnable <= regWdata[PSR_ET];
			supervisor <= regWdata[PSR_S];
			prevSup <= regWdata[PSR_PS];
			current_window_ptr <= regWdata[PSR_CWP_LO +: CWPW];
			cpu_irq_level <= regWdata[PSR_PIL_LO +: 4];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trap base and vectors
	always_ff @(posedge clk) begin
		if (srst) begin
			trap_table_base <= '0;
			trapType <= '0;
			trapTaken <= 1'b0;
			trapPc <= RESET_PC;
			trapNpc <= RESET_PC;
		end else begin
			trapTaken <= resetReq || takeTrap;
			if (wrTbr) trap_table_base <= regWdata[TBR_TBA_LO +: 20];
			if (resetReq) begin
				trapPc <= RESET_PC;
				trapNpc <= RESET_PC + PC_STEP;
			end else if (takeTrap) begin
				trapType <= selTt;
				trapPc <= {trap_table_base, selTt, 4'h0};
				trapNpc <= {trap_table_base, selTt, 4'h0} + PC_STEP;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// floating-point state and register file control
	always_ff @(posedge clk) begin
		if (srst) begin
			fpTrapMask <= '0;
			fpAccrued <= '0;
			fpCondCodes <= '0;
			fpCommit <= 1'b0;
			fpTrapFlag <= 1'b0;
			injKey <= '0;
			cntEn <= 1'b0;
			testChk <= '0;
			singleCnt <= '0;
			injData <= '0;
			rfErrFlag <= 1'b0;
			rfRdData <= '0;
			rfRdValid <= 1'b0;
			regRdata <= '0;
		end else begin
			fpCommit <= fpAccept;
			fpTrapFlag <= fpTrapNow;
			if (wrFsr) fpTrapMask <= regWdata[FSR_TEM_LO +: 5];
			fpAccrued <= (wrFsr ? regWdata[FSR_FP_ACCRUED_FLAGS_LO +: 5] : fpAccrued) | (fpAccept ? fpExc : 5'h00);
			if (fpAccept) fpCondCodes <= fpCcNew;
			else if (wrFsr) fpCondCodes <= regWdata[FSR_FCC_LO +: 2];
			if (wrFtc) begin
				injKey <= regWdata[FTC_KEY_LO +: 3];
				cntEn <= regWdata[FTC_CNTEN];
				testChk <= regWdata[FTC_TCB_LO +: 7];
			end
			if (wrInj) injData <= regWdata;
			singleCnt <= (wrFtc ? regWdata[FTC_CNT_LO +: 8] : singleCnt)
				+ 8'(cntEn && rfRdEn && singleErr);
			rfErrFlag <= rfRdEn && dblErr;
			rfRdValid <= rfRdEn;
			rfRdData <= fixWord;
			regRdata <= regRd ? rdMux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_fp_trap_blocks: assert property (fpTrapNow |=> !fpCommit && fpCondCodes == $past(fpCondCodes))
		else $error("fp trap let the result commit");
	a_fp_accrue: assert property (fpAccept |=> fpCommit && (fpAccrued & $past(fpExc)) == $past(fpExc))
		else $error("masked fp exception not accrued");
	a_tbr_low_zero: assert property (tbrVal[3:0] == 4'h0 && trapPc[3:0] == 4'h0 || $past(resetReq))
		else $error("trap base low bits not zero");
	a_entry_psr: assert property (takeTrap |=> !trapEnable && supervisor && prevSup == $past(supervisor))
		else $error("mode state wrong after entry");
	a_window_step: assert property (takeTrap |=> current_window_ptr == CWPW'($past(current_window_ptr) - 1'b1))
		else $error("window pointer not decremented");
	a_reset_vector: assert property (resetReq |=> trapTaken && trapPc == RESET_PC && trapNpc == PC_STEP)
		else $error("reset trap vector wrong");
	a_trap_vector: assert property (takeTrap |=> trapPc == tbrVal && trapNpc == trapPc + PC_STEP)
		else $error("trap vector not from trap base");
	a_halt_entry: assert property (goHalt |=> halted ##1 (halted || $past(resetReq)))
		else $error("no halt on trap with traps off");
	a_irq_ignored: assert property (!trapEnable && instrDone && excAll == '0 |=> !trapTaken || $past(resetReq))
		else $error("interrupt taken with traps off");
	a_rf_flag: assert property (rfRdEn && dblErr |=> rfErrFlag)
		else $error("uncorrectable error not flagged");
	a_rf_fatal: assert property (rfErrFlag && trapEnable && !halted && !resetReq
		&& !(excValid && (|excPend[EXC_RF-1:0])) |=> trapTaken && trapType == 8'h20)
		else $error("uncorrectable error not trapped");
	a_irq_level: assert property (takeTrap && !syncHit |-> irqLevel > cpu_irq_level)
		else $error("interrupt at or below cpu level");

	a_fp_no_accrue: assert property (fpTrapNow && !wrFsr |=> fpAccrued == $past(fpAccrued))
		else $error("trapped fp exception was accrued");
	a_tt_keep: assert property (resetReq |=> trapType == $past(trapType))
		else $error("reset trap changed the trap type");
	a_save_locals: assert property (takeTrap |=> rfData[$past(l1Idx)] == $past(curPc)
		&& rfData[$past(l2Idx)] == $past(curNpc))
		else $error("pc pair not saved in new window");
	a_rf_chk_store: assert property (rfWrEn && !injOn && !takeTrap
		|=> rfChk[$past(rfWrIdx)] == eccCheck(rfData[$past(rfWrIdx)]))
		else $error("checksum not stored with write");
	a_fix_writeback: assert property (rfRdEn && singleErr && !rfWrEn && !takeTrap
		|=> rfData[$past(rfRdIdx)] == rfRdData && !(^{rfData[$past(rfRdIdx)], rfChk[$past(rfRdIdx)]}))
		else $error("corrected word not written back");
	a_count_step: assert property (cntEn && rfRdEn && singleErr && !wrFtc
		|=> singleCnt == $past(singleCnt) + 8'h01)
		else $error("single error not counted");

	c_trap: cover property (takeTrap ##1 trapTaken);
	c_halt: cover property (goHalt ##1 halted);
	c_fix: cover property (rfRdEn && singleErr);
	c_fp_trap: cover property (fpTrapNow ##1 fpTrapFlag);
	c_irq: cover property (irqHit ##1 trapTaken);
endmodule : tee_trap_unit

// file: verification/tee_pipe_model.sv
`timescale 1ns/1ps
// pipeline stand-in: walks pc and next pc, follows trap redirects
module tee_pipe_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// pipeline events
	input  wire logic        instrDone,
	input  wire logic        trapTaken,
	input  wire logic [31:0] trapPc,
	input  wire logic [31:0] trapNpc,
	// program counters
	output logic      [31:0] curPc,
	output logic      [31:0] curNpc
);
	always_ff @(posedge clk) begin
		if (srst) begin
			curPc  <= 32'h0000_0100;
			curNpc <= 32'h0000_0104;
		end else if (trapTaken) begin
			curPc  <= trapPc;
			curNpc <= trapNpc;
		end else if (instrDone) begin
			curPc  <= curNpc;
			curNpc <= curNpc + 32'h0000_0004;
		end
	end
endmodule : tee_pipe_model

// file: verification/tee_trap_unit_tb_top.sv
`timescale 1ns/1ps
module tee_trap_unit_tb_top
	import tee_pkg::*;
;
	typedef struct {logic [76:0] v; logic [76:0] m;} tee_note_t;
	logic clk = 0, srst = 1, regWr = 0, regRd = 0, resetReq = 0, excValid = 0, instrDone = 0;
	logic fpValid = 0, rfWrEn = 0, rfRdEn = 0, trapTaken, halted, trapEnable, supervisor, fpCommit, rfRdValid;
	logic rdSeen = 0;
	logic [4:0]  regAddr = 0, fpExc = 0;
	logic [31:0] regWdata = 0, curPc, curNpc, regRdata, trapPc, trapNpc, rfWrData = 0, rfRdData;
	logic [15:0] excPend = 0;
	logic [6:0]  swTrapNum = 0;
	logic [3:0]  irqLevel = 0;
	logic [7:0]  trapType, rfWrIdx = 0, rfRdIdx = 0;
	logic [2:0]  current_window_ptr;
	logic [1:0]  fpCcNew = 0, fpCondCodes;
	int          n_mismatch = 0, samples_checked = 0, seed = 32'h49e1;
	tee_note_t   qReg[$], qTrap[$], qRf[$], qFp[$];
	always #2.5 clk = ~clk;
	tee_trap_unit i_tee_trap_unit (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .resetReq(resetReq), .excValid(excValid), .excPend(excPend),
		.swTrapNum(swTrapNum), .instrDone(instrDone), .irqLevel(irqLevel), .curPc(curPc), .curNpc(curNpc),
		.trapTaken(trapTaken), .trapType(trapType), .trapPc(trapPc), .trapNpc(trapNpc), .halted(halted),
		.trapEnable(trapEnable), .supervisor(supervisor), .current_window_ptr(current_window_ptr), .fpValid(fpValid), .fpExc(fpExc),
		.fpCcNew(fpCcNew), .fpCommit(fpCommit), .fpCondCodes(fpCondCodes), .rfWrEn(rfWrEn), .rfWrIdx(rfWrIdx),
		.rfWrData(rfWrData), .rfRdEn(rfRdEn), .rfRdIdx(rfRdIdx), .rfRdData(rfRdData), .rfRdValid(rfRdValid));
	tee_pipe_model i_tee_pipe_model (.clk(clk), .srst(srst), .instrDone(instrDone), .trapTaken(trapTaken),
		.trapPc(trapPc), .trapNpc(trapNpc), .curPc(curPc), .curNpc(curNpc));
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [76:0] got, input tee_note_t n);
		samples_checked++;
		if ((got & n.m) !== (n.v & n.m)) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got & n.m, n.v & n.m);
		end
	endtask : cmp
	task automatic cmp_trap(input tee_note_t n);
		cmp({trapType, trapPc, trapNpc, current_window_ptr, supervisor, trapEnable}, n);
	endtask : cmp_trap
	task automatic cmp_flag(input logic got, input logic e);
		cmp({76'h0, got}, '{{76'h0, e}, 77'h1});
	endtask : cmp_flag
	function automatic tee_note_t nw(input logic [31:0] v, input logic [31:0] m);
		return '{{45'h0, v}, {45'h0, m}};
	endfunction : nw
	function automatic logic [31:0] mkpsr(input logic [2:0] w, input logic et, input logic [3:0] cpu_irq_level);
		return {20'h0, cpu_irq_level, 1'b1, 1'b0, et, 2'b00, w};
	endfunction : mkpsr
	// expected trap entry: type, vector, new window, supervisor set, traps disabled
	task automatic note_trap(input logic [7:0] tt, input logic [31:0] v, input logic [2:0] w, input logic [7:0] ttm);
		qTrap.push_back('{{tt, v, v + 32'h0000_0004, w, 2'b10}, {ttm, {69{1'b1}}}});
	endtask : note_trap
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= wr;
		regRd    <= !wr;
		if (!wr) qReg.push_back(nw(d, m));
		@(posedge clk);
		regWr <= 0;
		regRd <= 0;
	endtask : bus
	task automatic req(input logic [15:0] p, input logic d, input logic [3:0] l, input logic r,
		output logic [31:0] pc, output logic [31:0] next_prog_counter);
		@(posedge clk);
		excValid  <= |p;
		excPend   <= p;
		instrDone <= d;
		irqLevel  <= l;
		resetReq  <= r;
		@(negedge clk);
		pc = curPc;
		next_prog_counter = curNpc;
		@(posedge clk);
		{excValid, excPend, instrDone, irqLevel, resetReq} <= '0;
		repeat (3) @(posedge clk);
	endtask : req
	task automatic rf(input logic wr, input logic [7:0] i, input logic [31:0] d, input logic [31:0] m);
		@(posedge clk);
		{rfWrEn, rfRdEn, rfWrIdx, rfRdIdx, rfWrData} <= {wr, !wr, i, i, d};
		if (!wr) qRf.push_back(nw(d, m));
		@(posedge clk);
		{rfWrEn, rfRdEn} <= 2'b00;
	endtask : rf
	task automatic fp(input logic [4:0] e, input logic [1:0] cc);
		@(posedge clk);
		{fpValid, fpExc, fpCcNew} <= {1'b1, e, cc};
		@(posedge clk);
		fpValid <= 0;
		repeat (3) @(posedge clk);
	endtask : fp
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) rdSeen <= regRd;
	always @(negedge clk) begin
		if (rdSeen && qReg.size() > 0) cmp({45'h0, regRdata}, qReg.pop_front());
		if (rfRdValid === 1'b1) cmp({45'h0, rfRdData}, qRf.size() ? qRf.pop_front() : nw(~rfRdData, '1));
		if (fpCommit === 1'b1) cmp({75'h0, fpCondCodes}, qFp.size() ? qFp.pop_front() : nw(32'h5, '1));
		if (trapTaken === 1'b1) cmp_trap(qTrap.size() ? qTrap.pop_front() : '{77'h1, 77'h0 - 77'h1});
	end
	initial begin
		#100000;
		n_mismatch++;
		complete_run();
	end
	initial begin : main
		logic [31:0] pc, next_prog_counter, d, tb;
		logic [15:0] p;
		logic [7:0]  tt;
		int          k;
		repeat (4) @(posedge clk);
		srst <= 0;
		bus(1, OFF_INJ, 0, 0);
		bus(1, OFF_FTC, 0, 0);
		bus(0, OFF_PSR, 32'h0000_0080, 32'h0000_0FBF);
		bus(1, OFF_TBR, 32'hABCD_E123, 0);
		bus(0, OFF_TBR, 32'hABCD_E000, 32'hFFFF_F00F);
		req(16'h0008, 0, 0, 0, pc, next_prog_counter);
		cmp_flag(halted, 1);
		note_trap(8'h00, RESET_PC, 3'h0, 8'h00);
		req(0, 0, 0, 1, pc, next_prog_counter);
		cmp_flag(halted, 0);
		req(0, 1, 4'hF, 0, pc, next_prog_counter);
		for (int i = 0; i < 6; i++) begin
			p = 16'($random(seed));
			if (p == 0) p = 16'h8000;
			for (k = 0; k < 15 && !p[k]; k++);
			d = $random(seed);
			swTrapNum <= d[6:0];
			tt = (k == 15) ? {1'b1, d[6:0]} : EXC_TT[k];
			tb = {20'hABCDE, tt, 4'h0};
			bus(1, OFF_PSR, mkpsr(i[2:0], 1, 4'h3), 0);
			note_trap(tt, tb, i[2:0] - 3'h1, 8'hFF);
			req(p, 1, 4'h9, 0, pc, next_prog_counter);
			rf(0, 8'(NGLOB + (i + 7) % 8 * WIN_SZ + LOC1), pc, '1);
			rf(0, 8'(NGLOB + (i + 7) % 8 * WIN_SZ + LOC2), next_prog_counter, '1);
		end
		bus(1, OFF_PSR, mkpsr(3'h2, 1, 4'h5), 0);
		req(0, 1, 4'h5, 0, pc, next_prog_counter);
		req(0, 0, 4'h7, 0, pc, next_prog_counter);
		note_trap(8'h16, 32'hABCD_E160, 3'h1, 8'hFF);
		req(0, 1, 4'h6, 0, pc, next_prog_counter);
		bus(1, OFF_FSR, 0, 0);
		qFp.push_back(nw(32'h2, 32'h3));
		fp(5'h01, 2'h2);
		bus(0, OFF_FSR, 32'h0000_0820, 32'h0000_0FE0);
		bus(1, OFF_FSR, 32'h0080_0000, 0);
		bus(1, OFF_PSR, mkpsr(3'h1, 1, 4'h0), 0);
		note_trap(8'h08, 32'hABCD_E080, 3'h0, 8'hFF);
		fp(5'h01, 2'h1);
		bus(0, OFF_FSR, 32'h0080_0000, 32'h0F80_0FE0);
		d = $random(seed);
		rf(1, 8'd20, d, 0);
		rf(0, 8'd20, d, '1);
		bus(1, OFF_FTC, 32'h1000_0000, 0);
		bus(1, OFF_INJ, 32'h0000_0001, 0);
		bus(1, OFF_FTC, 32'hB000_0000, 0);
		rf(1, 8'd21, d, 0);
		bus(1, OFF_FTC, 32'h1000_0000, 0);
		rf(0, 8'd21, d, '1);
		rf(0, 8'd21, d, '1);
		bus(0, OFF_FTC, 32'h0000_0001, 32'h0000_00FF);
		bus(1, OFF_PSR, mkpsr(3'h0, 1, 4'h0), 0);
		bus(1, OFF_INJ, 32'h0000_0003, 0);
		bus(1, OFF_FTC, 32'hA000_0000, 0);
		rf(1, 8'd22, d, 0);
		bus(1, OFF_FTC, 0, 0);
		note_trap(8'h20, 32'hABCD_E200, 3'h7, 8'hFF);
		rf(0, 8'd22, d, 0);
		repeat (10) @(posedge clk);
		cmp_flag(qTrap.size() == 0 && qRf.size() == 0 && qFp.size() == 0, 1);
		complete_run();
	end
endmodule : tee_trap_unit_tb_top
